// >>> svf_pkg.sv
// Constants for the self-test voltage fault status registers.
// Assumes one 100 MHz clock domain and a host-side serial engine that decodes reads.
package svf_pkg;

    localparam int unsigned SVF_REG_W = 8;

    // Bit positions shared by both status registers
    localparam int unsigned SVF_BIT_REGSUPPLY = 7;
    localparam int unsigned SVF_BIT_EXTMON_B  = 5;
    localparam int unsigned SVF_BIT_EXTMON_A  = 4;
    localparam int unsigned SVF_BIT_STEPUP    = 3;
    localparam int unsigned SVF_BIT_STEPDN_B  = 1;
    localparam int unsigned SVF_BIT_STEPDN_A  = 0;

    // Implemented flag bits; bits 6 and 2 are reserved
    localparam logic [SVF_REG_W-1:0] SVF_IMPL_MASK = 8'hbb;
    localparam logic [SVF_REG_W-1:0] SVF_RESET_VAL = 8'h00;

    // One flag per comparator, in the order of the comparator vector
    localparam int unsigned SVF_NUM_CMP = 6;

    // Positions inside the six-wide comparator vectors
    localparam int unsigned SVF_CMP_REGSUPPLY = 5;
    localparam int unsigned SVF_CMP_EXTMON_B  = 4;
    localparam int unsigned SVF_CMP_EXTMON_A  = 3;
    localparam int unsigned SVF_CMP_STEPUP    = 2;
    localparam int unsigned SVF_CMP_STEPDN_B  = 1;
    localparam int unsigned SVF_CMP_STEPDN_A  = 0;

    typedef logic [SVF_REG_W-1:0]   svf_reg_t;
    typedef logic [SVF_NUM_CMP-1:0] svf_cmp_t;

endpackage

// >>> svf_flag_if.sv
// Carrier between the status register top and its flag bank.
// Assumes all members are on the same clock as both modules.
interface svf_flag_if
    import svf_pkg::*;
();
    svf_reg_t set_err;
    svf_reg_t present;
    logic     rd_clr;
    svf_reg_t flags;

    modport bank (
        input  set_err,
        input  present,
        input  rd_clr,
        output flags
    );

    modport user (
        output set_err,
        output present,
        output rd_clr,
        input  flags
    );
endinterface

// >>> svf_flag_reg.sv
// One 8-bit sticky self-test fault register with clear-on-read.
// Assumes the set and present vectors are already placed at their bit positions.
module svf_flag_reg
    import svf_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // Flag bank
    svf_flag_if.bank  fif
);

    svf_reg_t flags_q;
    svf_reg_t flags_d;

    always_comb begin
        flags_d = flags_q;
        if (fif.rd_clr) begin
            // Only flags whose condition is gone drop on a read
            flags_d = flags_q & fif.present;
        end
        // A new fault wins over a read in the same cycle
        flags_d = (flags_d | fif.set_err) & SVF_IMPL_MASK;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q <= SVF_RESET_VAL;
        end else if (clk_en) begin
            flags_q <= flags_d;
        end
    end

    assign fif.flags = flags_q;

endmodule

// >>> svf_status_top.sv
// Self-test undervoltage and overvoltage fault status registers.
// Assumes strobes and condition levels come from the self-test engine on clk,
// and read strobes from the serial interface decoder, one cycle each.
// Clock enable low freezes flags, read data and valid alike.
// Reserved bits 6 and 2 read zero in both registers.
// Flags and read data reset asynchronously to zero.
//
// Behaviour
// - Each flag sets on its fault and stays set until its register is read.
// - A read clears a set flag only when its condition is gone.
// - Power-on reset zeroes all flags; afterwards only reads, faults and a later reset change them.
// - Flag value zero means no error, one means error detected.
// - Undervoltage bit 7 reports the regulator supply comparator.
// - Undervoltage bits 5 and 4 report second and first external monitor.
// - Undervoltage bits 3,1,0 report step-up, second, first step-down; 6,2 read zero.
// - Overvoltage bit 7 reports the regulator supply comparator.
// - Overvoltage bits 5 and 4 report second and first external monitor.
// - Overvoltage bits 3,1,0 report step-up, second, first step-down; 6,2 read zero.
module svf_status_top
    import svf_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire logic     clk_en,
    // Undervoltage self-test error strobes
    input  wire logic     st_regsupply_under_fault,
    input  wire logic     st_extmon_b_under_fault,
    input  wire logic     st_extmon_a_under_fault,
    input  wire logic     st_stepup_under_fault,
    input  wire logic     st_stepdown_b_under_fault,
    input  wire logic     st_stepdown_a_under_fault,
    // Overvoltage self-test error strobes
    input  wire logic     st_regsupply_over_fault,
    input  wire logic     st_extmon_b_over_fault,
    input  wire logic     st_extmon_a_over_fault,
    input  wire logic     st_stepup_over_fault,
    input  wire logic     st_stepdown_b_over_fault,
    input  wire logic     st_stepdown_a_over_fault,
    // Fault condition still present, same comparator order as the strobes
    input  wire svf_cmp_t under_present,
    input  wire svf_cmp_t over_present,
    // Register read strobes from the serial decoder
    input  wire logic     rd_under_stb,
    input  wire logic     rd_over_stb,
    // Read data and live register contents
    output svf_reg_t      under_rdata_q,
    output svf_reg_t      over_rdata_q,
    output logic          rdata_valid_q,
    output svf_reg_t      selftest_undervoltage_faults,
    output svf_reg_t      selftest_overvoltage_faults
);

    // Gather six per-comparator strobes into one comparator vector
    function automatic svf_cmp_t gather_cmp(
        input logic regsupply,
        input logic extmon_b,
        input logic extmon_a,
        input logic stepup,
        input logic stepdn_b,
        input logic stepdn_a
    );
        svf_cmp_t v;
        v                    = '0;
        v[SVF_CMP_REGSUPPLY] = regsupply;
        v[SVF_CMP_EXTMON_B]  = extmon_b;
        v[SVF_CMP_EXTMON_A]  = extmon_a;
        v[SVF_CMP_STEPUP]    = stepup;
        v[SVF_CMP_STEPDN_B]  = stepdn_b;
        v[SVF_CMP_STEPDN_A]  = stepdn_a;
        return v;
    endfunction

    // Place a comparator vector at the register's bits; reserved bits stay zero
    function automatic svf_reg_t place_bits(input svf_cmp_t v);
        svf_reg_t r;
        r                    = SVF_RESET_VAL;
        r[SVF_BIT_REGSUPPLY] = v[SVF_CMP_REGSUPPLY];
        r[SVF_BIT_EXTMON_B]  = v[SVF_CMP_EXTMON_B];
        r[SVF_BIT_EXTMON_A]  = v[SVF_CMP_EXTMON_A];
        r[SVF_BIT_STEPUP]    = v[SVF_CMP_STEPUP];
        r[SVF_BIT_STEPDN_B]  = v[SVF_CMP_STEPDN_B];
        r[SVF_BIT_STEPDN_A]  = v[SVF_CMP_STEPDN_A];
        return r;
    endfunction

    // Read view of a flag register; reserved bits never leave the block
    function automatic svf_reg_t read_view(input svf_reg_t flags);
        svf_reg_t r;
        r = flags & SVF_IMPL_MASK;
        return r;
    endfunction

    // Comparator strobes and live fault conditions
    svf_cmp_t under_stb;
    svf_cmp_t over_stb;
    svf_reg_t under_set_bits;
    svf_reg_t over_set_bits;
    svf_reg_t under_keep_bits;
    svf_reg_t over_keep_bits;

    // Reads taken this cycle, with the next read data and valid
    logic     rd_under_take;
    logic     rd_over_take;
    svf_reg_t under_rdata_d;
    svf_reg_t over_rdata_d;
    logic     rdata_valid_d;

    // Undervoltage strobes in comparator order
    assign under_stb = gather_cmp(
        st_regsupply_under_fault,
        st_extmon_b_under_fault,
        st_extmon_a_under_fault,
        st_stepup_under_fault,
        st_stepdown_b_under_fault,
        st_stepdown_a_under_fault
    );

    // Overvoltage strobes in comparator order
    assign over_stb = gather_cmp(
        st_regsupply_over_fault,
        st_extmon_b_over_fault,
        st_extmon_a_over_fault,
        st_stepup_over_fault,
        st_stepdown_b_over_fault,
        st_stepdown_a_over_fault
    );

    // Strobes and present levels at their register bits
    assign under_set_bits  = place_bits(under_stb);
    assign over_set_bits   = place_bits(over_stb);
    assign under_keep_bits = place_bits(under_present);
    assign over_keep_bits  = place_bits(over_present);

    // One carrier per status register
    svf_flag_if under_if ();
    svf_flag_if over_if ();

    // Undervoltage register wiring
    assign under_if.set_err = under_set_bits;
    assign under_if.present = under_keep_bits;
    assign under_if.rd_clr  = rd_under_stb;

    // Overvoltage register wiring
    assign over_if.set_err  = over_set_bits;
    assign over_if.present  = over_keep_bits;
    assign over_if.rd_clr   = rd_over_stb;

    // Each bank gives a new fault priority over the read's clear
    svf_flag_reg u_under (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .fif    (under_if.bank)
    );

    // Overvoltage flag bank
    svf_flag_reg u_over (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .fif    (over_if.bank)
    );

    // A read counts only while the clock enable is high
    assign rd_under_take = clk_en & rd_under_stb;
    assign rd_over_take  = clk_en & rd_over_stb;

    // Read data shows flags as they stood before the read's clear
    always_comb begin
        under_rdata_d = under_rdata_q;
        if (rd_under_take) begin
            under_rdata_d = read_view(under_if.flags);
        end
    end

    always_comb begin
        over_rdata_d = over_rdata_q;
        if (rd_over_take) begin
            over_rdata_d = read_view(over_if.flags);
        end
    end

    // Valid marks the cycle after any read
    always_comb begin
        rdata_valid_d = rd_under_take | rd_over_take;
    end

    // Clock enable low holds read data and valid with the flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            under_rdata_q <= SVF_RESET_VAL;
        end else if (clk_en) begin
            under_rdata_q <= under_rdata_d;
        end
    end

    // Overvoltage read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            over_rdata_q <= SVF_RESET_VAL;
        end else if (clk_en) begin
            over_rdata_q <= over_rdata_d;
        end
    end

    // Read valid pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_valid_q <= 1'b0;
        end else if (clk_en) begin
            rdata_valid_q <= rdata_valid_d;
        end
    end

    // Live register contents straight from the flag banks
    assign selftest_undervoltage_faults = under_if.flags;
    assign selftest_overvoltage_faults  = over_if.flags;

endmodule

// >>> svf_status_props.sv
// Checker for the self-test voltage fault status registers.
// Assumes it is bound onto svf_status_top, one clock domain.
module svf_status_props
    import svf_pkg::*;
(
    // Clock, reset and strobes
    input wire logic     clk,
    input wire logic     reset,
    input wire logic     clk_en,
    input wire logic     st_regsupply_under_fault,
    input wire logic     st_extmon_a_under_fault,
    input wire logic     st_regsupply_over_fault,
    input wire logic     st_extmon_b_over_fault,
    input wire svf_cmp_t under_present,
    input wire svf_cmp_t over_present,
    input wire logic     rd_under_stb,
    input wire logic     rd_over_stb,
    // Outputs watched
    input wire svf_reg_t over_rdata_q,
    input wire logic     rdata_valid_q,
    input wire svf_reg_t selftest_undervoltage_faults,
    input wire svf_reg_t selftest_overvoltage_faults
);
    timeunit 1ns;
    timeprecision 1ps;
    wire svf_reg_t u = selftest_undervoltage_faults;
    wire svf_reg_t o = selftest_overvoltage_faults;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rd_u;
        clk_en && rd_under_stb;
    endsequence
    sequence s_rd_o;
        clk_en && rd_over_stb;
    endsequence
    chk_rsvd_zero: assert property (((u | o) & ~SVF_IMPL_MASK) == 8'h00)
        else $error("reserved bit set");
    chk_uv_reg_set: assert property (clk_en && st_regsupply_under_fault |=> u[7])
        else $error("uv bit 7 not set");
    chk_uv_exta_set: assert property (clk_en && st_extmon_a_under_fault |=> u[4])
        else $error("uv bit 4 not set");
    chk_ov_reg_set: assert property (clk_en && st_regsupply_over_fault |=> o[7])
        else $error("ov bit 7 not set");
    chk_ov_extb_set: assert property (clk_en && st_extmon_b_over_fault |=> o[5])
        else $error("ov bit 5 not set");
    chk_uv_sticky: assert property (!(clk_en && rd_under_stb) |=> (u & $past(u)) == $past(u))
        else $error("uv flag lost without read");
    chk_uv_clear: assert property (s_rd_u ##0 !under_present[5] && !st_regsupply_under_fault |=> !u[7])
        else $error("uv flag not cleared");
    chk_uv_keep: assert property (s_rd_u ##0 under_present[5] && u[7] |=> u[7])
        else $error("uv flag cleared while present");
    chk_ov_keep: assert property (s_rd_o ##0 over_present[0] && o[0] |=> o[0])
        else $error("ov flag cleared while present");
    chk_ov_rdata: assert property (clk_en && rd_over_stb |=> over_rdata_q == $past(o) && rdata_valid_q)
        else $error("ov read data wrong");
endmodule
bind svf_status_top svf_status_props u_props (.clk, .reset, .clk_en, .st_regsupply_under_fault,
    .st_extmon_a_under_fault, .st_regsupply_over_fault, .st_extmon_b_over_fault, .under_present, .over_present,
    .rd_under_stb, .rd_over_stb, .over_rdata_q, .rdata_valid_q, .selftest_undervoltage_faults,
    .selftest_overvoltage_faults);

// >>> svf_host_model.sv
// Host model: issues one-cycle register read strobes.
// Assumes the bench calls rd; strobes change at falling edges.
module svf_host_model (
    // Clock and read strobes
    input  wire logic clk,
    output logic      rd_under_stb,
    output logic      rd_over_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rd_under_stb = 1'b0;
    initial rd_over_stb = 1'b0;
    task automatic rd(input logic ru, input logic ro);
        @(negedge clk);
        rd_under_stb = ru;
        rd_over_stb = ro;
        @(negedge clk);
        rd_under_stb = 1'b0;
        rd_over_stb = 1'b0;
    endtask
endmodule

// >>> tb.sv
// Testbench for the self-test voltage fault status registers.
// Assumes the host model issues reads; bench drives strobes at falling edges.
module tb
    import svf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic     clk = 0, reset = 1, clk_en = 0, vld, rdu, rdo;
    svf_cmp_t us = '0, os = '0, up = '0, op = '0;
    svf_reg_t urd, ord, uq, oq;
    int       n_mismatch = 0, check_count = 0;
    always #5 clk = ~clk;
    svf_status_top u_dut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .st_regsupply_under_fault(us[5]), .st_extmon_b_under_fault(us[4]), .st_extmon_a_under_fault(us[3]),
        .st_stepup_under_fault(us[2]), .st_stepdown_b_under_fault(us[1]), .st_stepdown_a_under_fault(us[0]),
        .st_regsupply_over_fault(os[5]), .st_extmon_b_over_fault(os[4]), .st_extmon_a_over_fault(os[3]),
        .st_stepup_over_fault(os[2]), .st_stepdown_b_over_fault(os[1]), .st_stepdown_a_over_fault(os[0]),
        .under_present(up), .over_present(op), .rd_under_stb(rdu), .rd_over_stb(rdo),
        .under_rdata_q(urd), .over_rdata_q(ord), .rdata_valid_q(vld),
        .selftest_undervoltage_faults(uq), .selftest_overvoltage_faults(oq));
    svf_host_model u_host (.clk(clk), .rd_under_stb(rdu), .rd_over_stb(rdo));
    function automatic svf_reg_t map(svf_cmp_t c);
        return {c[5], 1'b0, c[4:2], 1'b0, c[1:0]};
    endfunction
    task automatic chk(svf_reg_t seen, svf_reg_t exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic strobe(svf_cmp_t su, svf_cmp_t so);
        @(negedge clk);
        us = su;
        os = so;
        @(negedge clk);
        us = '0;
        os = '0;
    endtask
    task automatic t_map;
        for (int i = 0; i < SVF_NUM_CMP; i++) begin
            strobe(6'h01 << i, 6'h20 >> i);
            repeat (3) @(negedge clk);
            chk({7'h00, vld}, 8'h00);
            chk(uq, map(6'h01 << i));
            chk(oq, map(6'h20 >> i));
            u_host.rd(1'b1, 1'b1);
            chk(urd, map(6'h01 << i));
            chk(ord, map(6'h20 >> i));
            chk({7'h00, vld}, 8'h01);
            chk(uq | oq, 8'h00);
        end
    endtask
    task automatic t_present;
        up = 6'h20;
        op = 6'h01;
        strobe(6'h20, 6'h01);
        u_host.rd(1'b1, 1'b1);
        chk(uq, 8'h80);
        chk(oq, 8'h01);
        up = 6'h00;
        op = 6'h00;
        u_host.rd(1'b1, 1'b1);
        chk(urd, 8'h80);
        chk(ord, 8'h01);
        u_host.rd(1'b1, 1'b1);
        chk(urd, 8'h00);
        chk(ord, 8'h00);
    endtask
    task automatic t_setwins;
        fork
            strobe(6'h01, 6'h00);
            u_host.rd(1'b1, 1'b0);
        join
        chk(uq, 8'h01);
        chk(urd, 8'h00);
        u_host.rd(1'b1, 1'b0);
        chk(uq, 8'h00);
    endtask
    task automatic t_freeze;
        clk_en = 1'b0;
        strobe(6'h3f, 6'h3f);
        chk(uq | oq, 8'h00);
        clk_en = 1'b1;
    endtask
    task automatic t_reset;
        strobe(6'h3f, 6'h3f);
        u_host.rd(1'b0, 1'b1);
        reset = 1'b1;
        @(negedge clk);
        chk(uq | oq, 8'h00);
        chk(urd | ord, 8'h00);
        chk({7'h00, vld}, 8'h00);
        reset = 1'b0;
        strobe(6'h02, 6'h04);
        chk(uq, 8'h02);
        chk(oq, 8'h08);
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        clk_en = 1'b1;
        chk(uq | oq, 8'h00);
        t_map();
        t_present();
        t_setwins();
        t_freeze();
        t_reset();
        end_sim();
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
